// ### logic/gis_regs.sv
/*
 Second interrupt status/mask register pair: service request in,
 lockout, remote and command-out bits; only service request and command-out have enables.
 Assumes a synchronous 8-bit host port; bus conditions come
 from pins and are synchronised here.
*/
// Operation
// - Set service-request flag on condition rising
// - Clear it on reset or status read
// - Service request flag set only while in charge
// - Bit 5 shows lockout, never interrupts
// - Bit 4 shows remote state
// - Remote only with enable and listener address
// - Set command-out flag on condition rising
// - Clear command-out on read or state exit
// - Command-out set means command register empty
// - Mask bit 3 enables command-out interrupt
// - Summary is OR of enabled flags
// - Flag changes wait until read finishes
// - Status and mask share offset five
`default_nettype none
module gis_regs
  import gis_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  // Host port
  input  wire gis_host_req_t host_req,
  output var  logic [7:0]    rdata_q,
  output var  logic          rvalid_q,
  // Bus pins
  input  wire gis_gpib_t     gpib_pins,
  // Outputs
  output var  logic          irq_q,
  output var  logic          cmd_out_empty_q
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NPIN = $bits(gis_gpib_t);
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] stable_q;
  logic [NPIN-1:0] stable_d;
  gis_gpib_t       pin;

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_comb begin
        stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      stable_q <= '0;
    end else begin
      s1_q     <= gpib_pins;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= stable_d;
    end
  end
  assign pin = gis_gpib_t'(stable_q);

  // ****************************************************************
  // Remote/local function
  // ****************************************************************
  logic remote_q;
  logic lockout_q;

  gis_rl_state u_rl (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .ren         (pin.ren),
    .listen_addr (pin.listen_addr),
    .lockout_req (pin.lockout_req),
    .local_req   (pin.local_req),
    .remote_q    (remote_q),
    .lockout_q   (lockout_q)
  );

  // ****************************************************************
  // Status flags and mask
  // ****************************************************************
  logic       srq_cond;
  logic       co_cond;
  logic       srq_cond_q;
  logic       co_cond_q;
  logic       srq_cond_d;
  logic       co_cond_d;
  logic       srq_flag_q;
  logic       srq_flag_d;
  logic       co_flag_q;
  logic       co_flag_d;
  logic       srq_pend_q;
  logic       srq_pend_d;
  logic       co_set_pend_q;
  logic       co_set_pend_d;
  logic       co_clr_pend_q;
  logic       co_clr_pend_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic       rd_hit;
  logic       wr_hit;
  logic [7:0] rdata_d;
  logic       irq_d;

  // ****************************************************************
  // Host decode and mask register
  // ****************************************************************
  always_comb begin
    rd_hit   = host_req.rd && (host_req.addr == GIS_OFS_STAT_MASK);
    wr_hit   = host_req.wr && (host_req.addr == GIS_OFS_STAT_MASK);
    mask_d = mask_q;
    if (wr_hit) begin
      mask_d = host_req.wdata;
      // DMA enables held at zero; feature absent
      mask_d[GIS_BIT_DMA_TX] = 1'b0;
      mask_d[GIS_BIT_DMA_RX] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mask_q <= GIS_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ****************************************************************
  // Status flags, read clear and deferral
  // ****************************************************************
  always_comb begin
    srq_cond = pin.controller_in_charge && pin.srq && !(pin.rqs && pin.dav);
    co_cond  = pin.cacs && pin.sgns;
    srq_cond_d = srq_cond;
    co_cond_d  = co_cond;
    // Events during a read are held and applied afterwards
    srq_pend_d    = srq_pend_q || (srq_cond && !srq_cond_q);
    co_set_pend_d = co_set_pend_q || (co_cond && !co_cond_q);
    co_clr_pend_d = co_clr_pend_q || !co_cond;
    srq_flag_d = srq_flag_q;
    co_flag_d  = co_flag_q;
    if (rd_hit) begin
      srq_flag_d = 1'b0;
      co_flag_d  = 1'b0;
    end else begin
      if (srq_pend_d) begin
        srq_flag_d = 1'b1;
      end
      if (co_clr_pend_d && !co_cond) begin
        co_flag_d = 1'b0;
      end else if (co_set_pend_d) begin
        co_flag_d = 1'b1;
      end
      srq_pend_d    = 1'b0;
      co_set_pend_d = 1'b0;
      co_clr_pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      srq_cond_q    <= GIS_FLAG_RST;
      co_cond_q     <= GIS_FLAG_RST;
      srq_flag_q    <= GIS_FLAG_RST;
      co_flag_q     <= GIS_FLAG_RST;
      srq_pend_q    <= GIS_FLAG_RST;
      co_set_pend_q <= GIS_FLAG_RST;
      co_clr_pend_q <= GIS_FLAG_RST;
    end else begin
      srq_cond_q    <= srq_cond_d;
      co_cond_q     <= co_cond_d;
      srq_flag_q    <= srq_flag_d;
      co_flag_q     <= co_flag_d;
      srq_pend_q    <= srq_pend_d;
      co_set_pend_q <= co_set_pend_d;
      co_clr_pend_q <= co_clr_pend_d;
    end
  end

  // ****************************************************************
  // Read answer and summary interrupt
  // ****************************************************************
  always_comb begin
    rdata_d = 8'h00;
    rdata_d[GIS_BIT_SRQ]     = srq_flag_q;
    rdata_d[GIS_BIT_LOCKOUT] = lockout_q;
    rdata_d[GIS_BIT_REMOTE]  = remote_q;
    rdata_d[GIS_BIT_CMDOUT]  = co_flag_q;
    if (!rd_hit) begin
      rdata_d = 8'h00;
    end
    // Lockout has no enable and stays out of the summary
    irq_d = (srq_flag_d && mask_d[GIS_BIT_SRQ]) ||
            (co_flag_d && mask_d[GIS_BIT_CMDOUT]);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_q         <= 8'h00;
      rvalid_q        <= 1'b0;
      irq_q           <= 1'b0;
      cmd_out_empty_q <= 1'b0;
    end else begin
      rdata_q         <= rdata_d;
      rvalid_q        <= rd_hit;
      irq_q           <= irq_d;
      cmd_out_empty_q <= co_flag_d;
    end
  end
endmodule
`default_nettype wire

// ### logic/gis_pkg.sv
/*
 Package for the second interrupt status and mask register pair:
 offsets, field positions, reset values and carrier structs.
 Assumes one clock domain and an 8-bit host register port.
*/
`default_nettype none
package gis_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] GIS_OFS_STAT_MASK = 4'h5;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int GIS_BIT_SRQ     = 6;
  localparam int GIS_BIT_LOCKOUT = 5;
  localparam int GIS_BIT_REMOTE  = 4;
  localparam int GIS_BIT_CMDOUT  = 3;
  localparam int GIS_BIT_DMA_TX  = 5;
  localparam int GIS_BIT_DMA_RX  = 4;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] GIS_MASK_RST = 8'h00;
  localparam logic       GIS_FLAG_RST = 1'b0;
  localparam logic [1:0] GIS_SYNC_RST = 2'h0;
  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic controller_in_charge;
    logic srq;
    logic rqs;
    logic dav;
    logic cacs;
    logic sgns;
    logic ren;
    logic listen_addr;
    logic lockout_req;
    logic local_req;
  } gis_gpib_t;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } gis_host_req_t;
endpackage
`default_nettype wire

// ### logic/gis_rl_state.sv
/*
 Remote/local state tracker: remote and lockout levels.
 Assumes inputs already synchronised to clk_sys.
*/
`default_nettype none
module gis_rl_state
  import gis_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Bus conditions
  input  wire logic ren,
  input  wire logic listen_addr,
  input  wire logic lockout_req,
  input  wire logic local_req,
  // State
  output var  logic remote_q,
  output var  logic lockout_q
);
  logic remote_d;
  logic lockout_d;

  always_comb begin
    remote_d  = remote_q;
    lockout_d = lockout_q;
    if (!ren) begin
      remote_d  = 1'b0;
      lockout_d = 1'b0;
    end else begin
      if (listen_addr && !(local_req && !lockout_q)) begin
        remote_d = 1'b1;
      end else if (local_req && !lockout_q) begin
        remote_d = 1'b0;
      end
      if (lockout_req) begin
        lockout_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      remote_q  <= GIS_FLAG_RST;
      lockout_q <= GIS_FLAG_RST;
    end else begin
      remote_q  <= remote_d;
      lockout_q <= lockout_d;
    end
  end
endmodule
`default_nettype wire

// ### dv/gis_gpib_model.sv
/* Far-side bus model driving the bus condition levels.
   Assumes the bench calls its tasks in the clk_sys domain. */
`default_nettype none
module gis_gpib_model
  import gis_pkg::*;
(
  // Clock
  input  wire logic      clk_sys,
  // Bus levels
  output var  gis_gpib_t gpib_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Level driver
  // ********
  initial gpib_pins = '0;
  task automatic put(input gis_gpib_t v);
    @(posedge clk_sys);
    gpib_pins <= v;
  endtask
  task automatic go_remote();
    gis_gpib_t v;
    v = gpib_pins;
    v.ren = 1'b1;
    put(v);
    v.listen_addr = 1'b1;
    put(v);
  endtask
endmodule
`default_nettype wire

// ### dv/gis_regs_properties.sv
/* Port checker for the status/mask register pair.
   Assumes it is bound to gis_regs. */
`default_nettype none
module gis_regs_chk
  import gis_pkg::*;
(
  // Clock and reset
  input wire logic          clk_sys,
  input wire logic          rstn,
  // Watched ports
  input wire gis_host_req_t host_req,
  input wire logic [7:0]    rdata_q,
  input wire logic          rvalid_q,
  input wire gis_gpib_t     gpib_pins,
  input wire logic          irq_q,
  input wire logic          cmd_out_empty_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Properties
  // ********
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire logic hit;
  wire logic cond;
  assign hit = host_req.rd && host_req.addr == 4'h5;
  assign cond = gpib_pins.cacs && gpib_pins.sgns;
  a_read_answer:
    assert property (hit |=> rvalid_q) else $error("read not answered");
  a_miss_silent:
    assert property (host_req.rd && !hit |=> !rvalid_q)
    else $error("answer to unmapped read");
  a_rdata_idle:
    assert property (!rvalid_q |-> rdata_q == 8'h00)
    else $error("read data outside answer");
  a_reset_quiet:
    assert property ($rose(rstn) |-> !irq_q && !rvalid_q)
    else $error("outputs active after reset");
  a_cmd_set:
    assert property ($rose(cond) ##1 (cond && !host_req.rd)[*8]
    |-> cmd_out_empty_q) else $error("command-out flag not set");
  a_cmd_clear:
    assert property ($fell(gpib_pins.cacs) |-> ##[1:8] !cmd_out_empty_q)
    else $error("command-out flag not cleared");
  a_srq_idle:
    assert property ((!gpib_pins.controller_in_charge && !host_req.rd)[*8] ##1 hit
    ##1 (!gpib_pins.controller_in_charge)[*8] ##1 hit |=> !rdata_q[6])
    else $error("request flag without charge");
  a_remote_ren:
    assert property ((!gpib_pins.ren)[*8] ##1 hit |=> !rdata_q[4])
    else $error("remote without enable");
endmodule
bind gis_regs gis_regs_chk i_chk (.clk_sys, .rstn, .host_req, .rdata_q,
  .rvalid_q, .gpib_pins, .irq_q, .cmd_out_empty_q);
`default_nettype wire

// ### dv/tb.sv
/* Bench for gis_regs: host reads and writes, far-side levels.
   Assumes gis_pkg and the far-side model compiled first. */
`default_nettype none
module tb
  import gis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Harness
  // ********
  logic          clk_sys   = 1'b0;
  logic          rstn      = 1'b0;
  gis_host_req_t host_req  = '0;
  logic [7:0]    rdata_q;
  logic          rvalid_q;
  logic          irq_q;
  logic          cmd_out_empty_q;
  gis_gpib_t     gpib_pins;
  int            failures  = 0;
  int            tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  gis_regs i_dut (.clk_sys, .rstn, .host_req, .rdata_q, .rvalid_q,
    .gpib_pins, .irq_q, .cmd_out_empty_q);
  gis_gpib_model i_far (.clk_sys, .gpib_pins);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge clk_sys);
    host_req <= '{rd: 1'b0, wr: 1'b1, addr: 4'h5, wdata: v};
    @(posedge clk_sys);
    host_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic v);
    @(posedge clk_sys);
    host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    host_req.rd <= 1'b0;
    #1;
    chk({7'h00, rvalid_q}, {7'h00, v});
    chk(rdata_q, e);
  endtask
  task automatic pins(input gis_gpib_t v);
    i_far.put(v);
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_srq();
    wr(8'h40);
    pins('{controller_in_charge: 1'b1, srq: 1'b1, default: 1'b0});
    chk({7'h00, irq_q}, 8'h01);
    rd(4'h5, 8'h40, 1'b1);
    chk({7'h00, irq_q}, 8'h00);
    rd(4'h5, 8'h00, 1'b1);
    pins('0);
    pins('{srq: 1'b1, default: 1'b0});
    rd(4'h5, 8'h00, 1'b1);
    pins('{controller_in_charge: 1'b1, srq: 1'b1, rqs: 1'b1, dav: 1'b1, default: 1'b0});
    rd(4'h5, 8'h00, 1'b1);
    pins('0);
    $display("service request test done");
  endtask
  task automatic t_cmd();
    wr(8'h08);
    pins('{cacs: 1'b1, sgns: 1'b1, default: 1'b0});
    chk({7'h00, cmd_out_empty_q}, 8'h01);
    chk({7'h00, irq_q}, 8'h01);
    rd(4'h5, 8'h08, 1'b1);
    chk({7'h00, cmd_out_empty_q}, 8'h00);
    pins('0);
    pins('{cacs: 1'b1, sgns: 1'b1, default: 1'b0});
    chk({7'h00, cmd_out_empty_q}, 8'h01);
    pins('{cacs: 1'b1, default: 1'b0});
    chk({7'h00, cmd_out_empty_q}, 8'h00);
    wr(8'h00);
    pins('{cacs: 1'b1, sgns: 1'b1, default: 1'b0});
    chk({7'h00, irq_q}, 8'h00);
    chk({7'h00, cmd_out_empty_q}, 8'h01);
    pins('0);
    $display("command-out test done");
  endtask
  task automatic t_remote();
    wr(8'h4F);
    pins('{listen_addr: 1'b1, default: 1'b0});
    rd(4'h5, 8'h00, 1'b1);
    i_far.go_remote();
    pins('{ren: 1'b1, listen_addr: 1'b1, default: 1'b0});
    rd(4'h5, 8'h10, 1'b1);
    pins('{ren: 1'b1, listen_addr: 1'b1, lockout_req: 1'b1, default: 1'b0});
    rd(4'h5, 8'h30, 1'b1);
    chk({7'h00, irq_q}, 8'h00);
    pins('0);
    rd(4'h5, 8'h00, 1'b1);
    rd(4'h4, 8'h00, 1'b0);
    $display("remote test done");
  endtask
  task automatic t_defer();
    i_far.put('{controller_in_charge: 1'b1, srq: 1'b1, default: 1'b0});
    repeat (3) @(posedge clk_sys);
    rd(4'h5, 8'h00, 1'b1);
    rd(4'h5, 8'h40, 1'b1);
    pins('0);
    $display("read deferral test done");
  endtask
  task automatic t_reset();
    pins('{controller_in_charge: 1'b1, srq: 1'b1, default: 1'b0});
    pins('0);
    chk({7'h00, irq_q}, 8'h01);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({7'h00, irq_q}, 8'h00);
    rd(4'h5, 8'h00, 1'b1);
    $display("reset test done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(4'h5, 8'h00, 1'b1);
    t_srq();
    t_defer();
    t_cmd();
    t_remote();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
